//--- core/spx_lock_detect.v
`timescale 1ns/10ps
`include "spx_regs.vh"

// Counts consecutive valid samples and declares lock or loss of lock
module spx_lock_detect #(
   parameter [6:0] NORMAL_COUNT = `SPX_LOCK_COUNT_NORMAL,
   parameter [6:0] QUICK_COUNT  = `SPX_LOCK_COUNT_QUICK
) (
   input  wire       ref_clk_i,
   input  wire       reset_n_i,
   input  wire       quick_acquire_i,
   input  wire       sample_strobe_i,
   input  wire       sample_ok_i,
   output wire       locked_o,
   output reg        lock_gained_o,
   output reg        lock_lost_o
);

   localparam [1:0] ST_HUNT   = 2'b01;
   localparam [1:0] ST_LOCKED = 2'b10;

   reg [1:0] state_q;
   reg [6:0] count_q;
   wire [6:0] threshold;

   // Eight samples in quick mode, sixty-four otherwise
   assign threshold = quick_acquire_i ? QUICK_COUNT : NORMAL_COUNT;
   assign locked_o  = state_q[1];

   // Hunt and lock state machine
   always @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         state_q       <= ST_HUNT;
         count_q       <= 7'h00;
         lock_gained_o <= 1'b0;
         lock_lost_o   <= 1'b0;
      end else begin
         lock_gained_o <= 1'b0;
         lock_lost_o   <= 1'b0;
         case (state_q)
            ST_HUNT: begin
               if (sample_strobe_i) begin
                  if (!sample_ok_i) begin
                     count_q <= 7'h00;
                  end else if (count_q + 7'h01 >= threshold) begin
                     count_q       <= 7'h00;
                     state_q       <= ST_LOCKED;
                     lock_gained_o <= 1'b1;
                  end else begin
                     count_q <= count_q + 7'h01;
                  end
               end
            end
            ST_LOCKED: begin
               // A single bad sample drops lock
               if (sample_strobe_i && !sample_ok_i) begin
                  state_q     <= ST_HUNT;
                  lock_lost_o <= 1'b1;
               end
            end
            default: begin
               state_q <= ST_HUNT;
               count_q <= 7'h00;
            end
         endcase
      end
   end

endmodule // spx_lock_detect

//--- core/spx_regs.vh
`ifndef SPX_REGS_VH
`define SPX_REGS_VH

// Register offsets, word addressed
`define SPX_LOCK_STATUS_OFS  16'hF600
`define SPX_CONTROL_OFS      16'hF601
`define SPX_DECODE_OFS       16'hF602
`define SPX_COMPR_CODE_OFS   16'hF603
`define SPX_INT_STATUS_OFS   16'hF610
`define SPX_INT_MASK_OFS     16'hF611

// Reset values
`define SPX_CONTROL_RST      4'h0
`define SPX_DECODE_RST       10'h000
`define SPX_COMPR_CODE_RST   16'h0000
`define SPX_INT_MASK_RST     3'h0

// Control field positions
`define SPX_CTL_QUICK_BIT    3
`define SPX_CTL_HOLD_BIT     2
`define SPX_CTL_WLEN_HI      1
`define SPX_CTL_WLEN_LO      0

// Word length select codes
`define SPX_WLEN_SEL_24      2'h0
`define SPX_WLEN_SEL_20      2'h1
`define SPX_WLEN_SEL_16      2'h2
`define SPX_WLEN_SEL_AUTO    2'h3

// Word lengths in bits
`define SPX_WLEN_24          5'h18
`define SPX_WLEN_20          5'h14
`define SPX_WLEN_16          5'h10

// Decode status field positions
`define SPX_DEC_RIGHT_HI     9
`define SPX_DEC_RIGHT_LO     6
`define SPX_DEC_LEFT_HI      5
`define SPX_DEC_LEFT_LO      2
`define SPX_DEC_FAMILY_BIT   1
`define SPX_DEC_KIND_BIT     0

// Interrupt status bit positions
`define SPX_INT_GAINED_BIT   0
`define SPX_INT_LOST_BIT     1
`define SPX_INT_DECODE_BIT   2

// Consecutive valid samples needed for lock
`define SPX_LOCK_COUNT_NORMAL 7'h40
`define SPX_LOCK_COUNT_QUICK  7'h08

`endif

//--- core/spx_rx_regs.v
`timescale 1ns/10ps
`include "spx_regs.vh"

module spx_rx_regs #(
   parameter [6:0] NORMAL_COUNT = `SPX_LOCK_COUNT_NORMAL,
   parameter [6:0] QUICK_COUNT  = `SPX_LOCK_COUNT_QUICK
) (
   input  wire        ref_clk_i,
   input  wire        reset_n_i,
   // Register port
   input  wire [15:0] reg_addr_i,
   input  wire [15:0] reg_wdata_i,
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   output reg  [15:0] reg_rdata_o,
   // From the biphase decoder, same clock
   input  wire        sample_strobe_i,
   input  wire        sample_ok_i,
   input  wire        frame_tick_i,
   input  wire        info_strobe_i,
   input  wire [3:0]  right_detected_width_i,
   input  wire [3:0]  left_detected_width_i,
   input  wire        compressed_i,
   input  wire        compression_family_i,
   input  wire [15:0] compression_code_i,
   input  wire [4:0]  status_word_length_i,
   // To the audio path
   output reg         frame_clock_o,
   output reg         audio_mute_o,
   output reg  [4:0]  word_length_o,
   output wire        locked_o,
   output wire        irq_o
);

   reg  [3:0]  control_q;
   reg  [9:0]  decode_q;
   reg  [15:0] compression_code_q;
   wire [2:0]  int_status_q;
   reg  [2:0]  int_mask_q;
   reg         ever_locked_q;
   reg  [15:0] rdata_d;
   reg  [4:0]  word_length_d;
   reg         frame_clock_d;
   wire        locked;
   wire        lock_gained;
   wire        lock_lost;
   wire [2:0]  int_events;
   wire        status_read;
   wire        quick_acquire;
   wire        frame_clock_hold_policy;
   wire [1:0]  word_length_select;
   wire [9:0]  decode_d;
   wire        sel_lock;
   wire        sel_control;
   wire        sel_decode;
   wire        sel_compr_code;
   wire        sel_int_status;
   wire        sel_int_mask;

   // Maps the detected code to bits, zero for unknown codes
   function [4:0] code_to_bits;
      input [3:0] code;
      begin
         case (code)
            4'h2:    code_to_bits = 5'h10;
            4'hC:    code_to_bits = 5'h11;
            4'h4:    code_to_bits = 5'h12;
            4'h8:    code_to_bits = 5'h13;
            4'hA:    code_to_bits = 5'h14;
            4'hD:    code_to_bits = 5'h15;
            4'h5:    code_to_bits = 5'h16;
            4'h9:    code_to_bits = 5'h17;
            4'hB:    code_to_bits = 5'h18;
            4'h3:    code_to_bits = 5'h14;
            default: code_to_bits = 5'h00;
         endcase
      end
   endfunction

   // True when the bus address selects the given register offset
   function addr_hit;
      input [15:0] addr;
      input [15:0] offset;
      begin
         addr_hit = (addr == offset);
      end
   endfunction

   assign quick_acquire           = control_q[`SPX_CTL_QUICK_BIT];
   assign frame_clock_hold_policy = control_q[`SPX_CTL_HOLD_BIT];
   assign word_length_select      = control_q[`SPX_CTL_WLEN_HI:`SPX_CTL_WLEN_LO];

   // Register selects, shared by the write, clear and read paths
   assign sel_lock       = addr_hit(reg_addr_i, `SPX_LOCK_STATUS_OFS);
   assign sel_control    = addr_hit(reg_addr_i, `SPX_CONTROL_OFS);
   assign sel_decode     = addr_hit(reg_addr_i, `SPX_DECODE_OFS);
   assign sel_compr_code = addr_hit(reg_addr_i, `SPX_COMPR_CODE_OFS);
   assign sel_int_status = addr_hit(reg_addr_i, `SPX_INT_STATUS_OFS);
   assign sel_int_mask   = addr_hit(reg_addr_i, `SPX_INT_MASK_OFS);

   // Lock detection
   spx_lock_detect #(
      .NORMAL_COUNT (NORMAL_COUNT),
      .QUICK_COUNT  (QUICK_COUNT)
   ) u_lock (
      .ref_clk_i       (ref_clk_i),
      .reset_n_i       (reset_n_i),
      .quick_acquire_i (quick_acquire),
      .sample_strobe_i (sample_strobe_i),
      .sample_ok_i     (sample_ok_i),
      .locked_o        (locked),
      .lock_gained_o   (lock_gained),
      .lock_lost_o     (lock_lost)
   );

   assign locked_o = locked;

   // Control register, only the four defined bits are stored
   always @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         control_q <= `SPX_CONTROL_RST;
      end else if (reg_wr_i && sel_control) begin
         control_q <= reg_wdata_i[3:0];
      end
   end

   // Interrupt mask register, same layout as the status
   always @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         int_mask_q <= `SPX_INT_MASK_RST;
      end else if (reg_wr_i && sel_int_mask) begin
         int_mask_q <= reg_wdata_i[2:0];
      end
   end

   // Packed decode status from the decoder
   assign decode_d = {right_detected_width_i,
                      left_detected_width_i,
                      compression_family_i,
                      compressed_i};

   // Stream information captured when the decoder presents it
   always @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         decode_q           <= `SPX_DECODE_RST;
         compression_code_q <= `SPX_COMPR_CODE_RST;
      end else if (info_strobe_i) begin
         decode_q           <= decode_d;
         compression_code_q <= compression_code_i;
      end
   end

   // Remembers whether lock was ever reached since reset
   always @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         ever_locked_q <= 1'b0;
      end else if (lock_gained) begin
         ever_locked_q <= 1'b1;
      end
   end

   // Frame clock gating by hold policy
   always @* begin
      if (frame_clock_hold_policy) begin
         frame_clock_d = frame_tick_i & locked;
      end else begin
         frame_clock_d = frame_tick_i & (locked | ever_locked_q);
      end
   end

   // Effective word length
   always @* begin
      case (word_length_select)
         `SPX_WLEN_SEL_24: word_length_d = `SPX_WLEN_24;
         `SPX_WLEN_SEL_20: word_length_d = `SPX_WLEN_20;
         `SPX_WLEN_SEL_16: word_length_d = `SPX_WLEN_16;
         default:          word_length_d = status_word_length_i;
      endcase
   end

   // Audio path outputs
   always @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         frame_clock_o <= 1'b0;
         audio_mute_o  <= 1'b1;
         word_length_o <= `SPX_WLEN_24;
      end else begin
         frame_clock_o <= frame_clock_d;
         audio_mute_o  <= ~locked;
         word_length_o <= word_length_d;
      end
   end

   // Interrupt events: lock gained, lock lost, changed decode status
   assign int_events  = {info_strobe_i & (decode_d != decode_q), lock_lost, lock_gained};
   assign status_read = reg_rd_i && sel_int_status;

   // Sticky status, one flag per event, cleared by read
   genvar ev;
   generate
      for (ev = 0; ev < 3; ev = ev + 1) begin : g_sticky
         reg flag_q;
         always @(posedge ref_clk_i) begin
            if (!reset_n_i) begin
               flag_q <= 1'b0;
            end else if (int_events[ev]) begin
               flag_q <= 1'b1;   // A new event wins over a same-cycle clear
            end else if (status_read) begin
               flag_q <= 1'b0;
            end
         end
         assign int_status_q[ev] = flag_q;
      end
   endgenerate

   assign irq_o = |(int_status_q & int_mask_q);

   // Read decode, reserved bits read zero
   always @* begin
      if (sel_lock) begin
         rdata_d = {15'h0000, locked};
      end else if (sel_control) begin
         rdata_d = {12'h000, control_q};
      end else if (sel_decode) begin
         rdata_d = {6'h00, decode_q};
      end else if (sel_compr_code) begin
         rdata_d = compression_code_q;
      end else if (sel_int_status) begin
         rdata_d = {13'h0000, int_status_q};
      end else if (sel_int_mask) begin
         rdata_d = {13'h0000, int_mask_q};
      end else begin
         rdata_d = 16'h0000;
      end
   end

   // Read data valid the cycle after the strobe only
   always @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         reg_rdata_o <= 16'h0000;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rdata_d;
      end else begin
         reg_rdata_o <= 16'h0000;
      end
   end

endmodule // spx_rx_regs

//--- verif/spx_rx_regs_asserts.sv
`timescale 1ns/10ps
// Pin-level checks of register port, lock and frame clock
module spx_rx_regs_asserts #(
   parameter [6:0] NORMAL_COUNT = 7'h40,
   parameter [6:0] QUICK_COUNT  = 7'h08
) (
   input wire logic        ref_clk_i,
   input wire logic        reset_n_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic        sample_strobe_i,
   input wire logic        sample_ok_i,
   input wire logic [4:0]  status_word_length_i,
   input wire logic        frame_clock_o,
   input wire logic        audio_mute_o,
   input wire logic [4:0]  word_length_o,
   input wire logic        locked_o,
   input wire logic        irq_o
);
   logic [3:0] ctl_q;
   logic [2:0] mask_q;
   logic [6:0] run_q;
   wire  [6:0] thr = ctl_q[3] ? QUICK_COUNT : NORMAL_COUNT;
   wire  [4:0] flen = (ctl_q[1:0] == 2'h0) ? 5'h18 : (ctl_q[1:0] == 2'h1) ? 5'h14 : 5'h10;

   // Mirrors of control and mask, run of good samples
   always @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         ctl_q  <= 4'h0;
         mask_q <= 3'h0;
         run_q  <= 7'h00;
      end else begin
         if (reg_wr_i && reg_addr_i == 16'hf601) ctl_q <= reg_wdata_i[3:0];
         if (reg_wr_i && reg_addr_i == 16'hf611) mask_q <= reg_wdata_i[2:0];
         if (sample_strobe_i) run_q <= !sample_ok_i ? 7'h00 : (run_q == 7'h7f) ? run_q : run_q + 7'h01;
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);

   a_rdata_idle: assert property (!$past(reg_rd_i) |->
      reg_rdata_o == 16'h0000) else $error("stray read data");
   a_ctl_readback: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 16'hf601 |->
      reg_rdata_o == {12'h000, $past(ctl_q)}) else $error("control readback");
   a_lock_read: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 16'hf600 |->
      reg_rdata_o == {15'h0000, $past(locked_o)}) else $error("lock flag readback");
   a_lock_count: assert property (!locked_o && sample_strobe_i && sample_ok_i && run_q == thr - 7'h01
      |=> locked_o) else $error("lock not declared");
   a_lock_early: assert property (!locked_o && run_q + 7'h01 < thr |=>
      !locked_o) else $error("early lock");
   a_lock_loss: assert property (locked_o && sample_strobe_i && !sample_ok_i |=>
      !locked_o) else $error("lock kept");
   a_mute_follow: assert property (audio_mute_o == !$past(locked_o)) else $error("mute wrong");
   a_weak_stop: assert property (!locked_o && ctl_q[2] |=>
      !frame_clock_o) else $error("frame clock ran");
   a_fixed_len: assert property ($stable(ctl_q) && ctl_q[1:0] != 2'h3 |->
      word_length_o == flen) else $error("forced length");
   a_auto_len: assert property ($stable(ctl_q) && ctl_q[1:0] == 2'h3 && $stable(status_word_length_i) |->
      word_length_o == status_word_length_i) else $error("auto length");
   a_irq_masked: assert property (mask_q == 3'h0 |-> !irq_o) else $error("masked interrupt");

   c_lock: cover property ($rose(locked_o));
   c_loss: cover property ($fell(locked_o));
   c_irq: cover property ($rose(irq_o));
endmodule // spx_rx_regs_asserts

bind spx_rx_regs spx_rx_regs_asserts #(.NORMAL_COUNT(NORMAL_COUNT), .QUICK_COUNT(QUICK_COUNT)) chk_u (.*);

//--- verif/spx_rx_regs_tb.sv
`timescale 1ns/10ps
// Reads note their expected word; a monitor compares each answer
module spx_rx_regs_tb;
   logic        ref_clk_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic [15:0] reg_addr_i = 16'h0000;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic        info_strobe_i = 1'b0;
   logic [3:0]  right_detected_width_i = 4'h0;
   logic [3:0]  left_detected_width_i = 4'h0;
   logic        compressed_i = 1'b0;
   logic        compression_family_i = 1'b0;
   logic [15:0] compression_code_i = 16'h0000;
   logic [4:0]  status_word_length_i = 5'h00;
   logic        run = 1'b0;
   logic        bad = 1'b0;
   wire         sample_strobe_i, sample_ok_i, frame_tick_i;
   wire  [15:0] reg_rdata_o;
   wire  [4:0]  word_length_o;
   wire         frame_clock_o, audio_mute_o, locked_o, irq_o;
   logic [15:0] exp_q[$];
   logic        rd_d = 1'b0;
   int          bad_count = 0;
   int          n_tests = 0;
   int          cyc = 0;
   logic [3:0]  codes[10] = '{4'h2, 4'hc, 4'h4, 4'h8, 4'ha, 4'hd, 4'h5, 4'h9, 4'hb, 4'h3};

   spx_rx_regs #(.NORMAL_COUNT(7'h08), .QUICK_COUNT(7'h04)) dut_u (.*);
   spx_src_model src_u (.clk_i(ref_clk_i), .run_i(run), .bad_i(bad), .strobe_o(sample_strobe_i),
      .ok_o(sample_ok_i), .tick_o(frame_tick_i));

   initial begin
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("compared %0d, mismatched %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Strobe for one cycle, then one idle cycle
   task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= w;
      reg_rd_i    <= !w;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask

   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      acc(1'b0, a, 16'h0000);
   endtask

   task automatic wait_lock(input logic v);
      for (int i = 0; i < 80 && locked_o !== v; i++) @(posedge ref_clk_i);
      chk({15'h0000, locked_o}, {15'h0000, v});
   endtask

   task automatic watch_fc(output logic seen);
      seen = 1'b0;
      repeat (2) @(posedge ref_clk_i);
      repeat (12) begin
         @(posedge ref_clk_i);
         seen = seen | frame_clock_o;
      end
   endtask

   // Answer monitor and run limit
   always @(posedge ref_clk_i) begin
      rd_d <= reg_rd_i;
      if (rd_d) chk(reg_rdata_o, exp_q.pop_front());
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         finish_test();
      end
   end

   initial begin
      logic [15:0] d;
      logic        fc;
      void'($urandom(15605));
      repeat (8) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      @(posedge ref_clk_i);
      rd(16'hf600, 16'h0000);
      rd(16'hf601, 16'h0000);
      rd(16'hf602, 16'h0000);
      rd(16'hf603, 16'h0000);
      rd(16'hf6ff, 16'h0000);
      chk({11'h000, word_length_o}, 16'h0018);
      $display("test reset done");
      for (int s = 0; s < 4; s++) begin
         d = 16'($urandom) & 16'hfff0 | 16'(s);
         status_word_length_i <= 5'($urandom_range(16, 24));
         acc(1'b1, 16'hf601, d);
         rd(16'hf601, {12'h000, d[3:0]});
         chk({11'h000, word_length_o}, s == 3 ? {11'h000, status_word_length_i} : 16'h0018 - 16'(s * 4));
      end
      $display("test word length done");
      acc(1'b1, 16'hf601, 16'h000c);
      run <= 1'b1;
      wait_lock(1'b1);
      rd(16'hf600, 16'h0001);
      chk({15'h0000, audio_mute_o}, 16'h0000);
      bad <= 1'b1;
      wait_lock(1'b0);
      watch_fc(fc);
      chk({15'h0000, fc}, 16'h0000);
      chk({15'h0000, audio_mute_o}, 16'h0001);
      acc(1'b1, 16'hf601, 16'h0000);
      bad <= 1'b0;
      wait_lock(1'b1);
      bad <= 1'b1;
      wait_lock(1'b0);
      watch_fc(fc);
      chk({15'h0000, fc}, 16'h0001);
      run <= 1'b0;
      $display("test lock done");
      chk({15'h0000, irq_o}, 16'h0000);
      acc(1'b1, 16'hf611, 16'hffff);
      rd(16'hf611, 16'h0007);
      chk({15'h0000, irq_o}, 16'h0001);
      rd(16'hf610, 16'h0003);
      chk({15'h0000, irq_o}, 16'h0000);
      for (int i = 0; i < 10; i++) begin
         right_detected_width_i <= codes[i];
         left_detected_width_i  <= codes[9 - i];
         compressed_i           <= i[0];
         compression_family_i   <= i[0] & 1'($urandom);
         compression_code_i     <= 16'($urandom);
         info_strobe_i          <= 1'b1;
         @(posedge ref_clk_i);
         info_strobe_i <= 1'b0;
         acc(1'b1, 16'hf602, 16'hffff);
         rd(16'hf602, {6'h00, codes[i], codes[9 - i],
            compression_family_i, compressed_i});
         rd(16'hf603, compression_code_i);
      end
      acc(1'b1, 16'hf611, 16'h0000);
      chk({15'h0000, irq_o}, 16'h0000);
      acc(1'b1, 16'hf611, 16'h0004);
      chk({15'h0000, irq_o}, 16'h0001);
      rd(16'hf610, 16'h0004);
      chk({15'h0000, irq_o}, 16'h0000);
      $display("test decode and interrupt done");
      finish_test();
   end
endmodule // spx_rx_regs_tb

//--- verif/spx_src_model.sv
`timescale 1ns/10ps
// Stream source: one sample every second cycle, a frame tick every fourth
module spx_src_model (
   input  wire logic clk_i,
   input  wire logic run_i,
   input  wire logic bad_i,
   output logic      strobe_o = 1'b0,
   output logic      ok_o     = 1'b0,
   output logic      tick_o   = 1'b0
);
   logic [1:0] ph_q = 2'h0;

   // Samples marked bad on request; the flag toggles between samples
   always @(posedge clk_i) begin
      ph_q     <= ph_q + 2'h1;
      strobe_o <= run_i & ph_q[0];
      ok_o     <= (run_i & ph_q[0]) ? !bad_i : !ok_o;
      tick_o   <= run_i & (ph_q == 2'h3);
   end
endmodule // spx_src_model
